// ===== design/auto_gain_loop.sv
/*
 automatic gain loop: steps a five-bit gain code up or down from strength
 hints. assumes hint inputs are already on sys_clk.
*/
`timescale 1ns/1ps
`include "rx_gain_tx_shaping_defs.svh"

module auto_gain_loop
   import rx_gain_tx_shaping_pkg::*;
(
   input  wire logic           sys_clk,
   input  wire logic           rst,
   input  wire logic           enable,
   input  wire gain_loop_cfg_t cfg,
   input  wire logic           preamble_seen,
   input  wire logic           signal_high,
   input  wire logic           signal_low,
   output gain_setting_t       gain
);
   logic [3:0] rise_cnt;
   gain_step_t step;
   logic       frozen;

   // while preamble_seen is high the gain is held, unless told to ignore it
   assign frozen = preamble_seen & ~cfg.gain_ignore_preamble;

   always_comb begin
      if (!enable || frozen)
         step = GAIN_HOLD;
      else if (signal_high)
         step = GAIN_DOWN;
      else if (signal_low)
         step = GAIN_UP;
      else
         step = GAIN_HOLD;
   end

   // rise pacing only; reductions stay immediate
   always_ff @(posedge sys_clk) begin
      if (rst || step != GAIN_UP || rise_cnt == `SLOW_RISE_DIV)
         rise_cnt <= 4'h0;
      else
         rise_cnt <= rise_cnt + 4'h1;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         gain <= '0;
      end else begin
         unique case (step)
            GAIN_DOWN: begin
               if (gain.var_amp_gain != 4'h0)
                  gain.var_amp_gain <= gain.var_amp_gain - 4'h1;
               else
                  gain.front_amp_gain_sel <= 1'b0;
            end
            GAIN_UP: begin
               if (!cfg.slow_gain_rise || rise_cnt == `SLOW_RISE_DIV) begin
                  if (!gain.front_amp_gain_sel)
                     gain.front_amp_gain_sel <= 1'b1;
                  else if (gain.var_amp_gain < `VAR_AMP_MAX_CODE)
                     gain.var_amp_gain <= gain.var_amp_gain + 4'h1;
               end
            end
            GAIN_HOLD: ;
            default: ;
         endcase
      end
   end
endmodule

// ===== design/rx_gain_tx_shaping_defs.svh
/*
 register offsets, reset values, field positions and table defaults for the
 receive gain / transmit shaping register bank. assumes byte-wide register port.
*/
`ifndef RX_GAIN_TX_SHAPING_DEFS_SVH
`define RX_GAIN_TX_SHAPING_DEFS_SVH

`define OFS_GAIN_MANUAL_OVERRIDE 7'h69
`define OFS_GAIN_LOOP_TUNING     7'h6a
`define OFS_TX_SHAPING_COEF_IDX  7'h6b
`define OFS_TX_SHAPING_COEF_VAL  7'h6c
`define OFS_TX_POWER_LEVEL       7'h6d
`define OFS_TX_RATE_HIGH         7'h6e
`define OFS_TX_RATE_LOW          7'h6f
`define OFS_TX_MOD_CTRL          7'h70

`define RST_GAIN_MANUAL_OVERRIDE 8'h20
`define RST_GAIN_LOOP_TUNING     8'h9d
`define RST_TX_POWER_LEVEL       4'h8
`define RST_TX_RATE_HIGH         8'h0a
`define RST_TX_RATE_LOW          8'h3d
`define RST_TX_MOD_CTRL          6'h00
`define RST_COEF_INDEX           3'h0

`define COEF_DEF_0 6'h01
`define COEF_DEF_1 6'h03
`define COEF_DEF_2 6'h06
`define COEF_DEF_3 6'h0a
`define COEF_DEF_4 6'h0f
`define COEF_DEF_5 6'h13
`define COEF_DEF_6 6'h14

`define BIT_AUTO_GAIN_ON       5
`define BIT_FRONT_AMP_GAIN_SEL 4
`define BIT_GAIN_IGNORE_PRE    7
`define BIT_SLOW_GAIN_RISE     6
`define BIT_RX_SWITCH_CTRL_EN  3
`define BIT_TX_RATE_SCALE      5

`define VAR_AMP_MAX_CODE   4'h8
`define SLOW_RISE_DIV      4'hf
`define GAIN_MAX           5'h18

`endif

// ===== design/rx_gain_tx_shaping_pkg.sv
/*
 types for the register bank: gain fields and the register port bundle.
 assumes the defs header is included where constants are needed.
*/
package rx_gain_tx_shaping_pkg;
   typedef struct packed {
      logic       front_amp_gain_sel;
      logic [3:0] var_amp_gain;
   } gain_setting_t;

   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [6:0] addr;
      logic [7:0] wdata;
   } reg_access_t;

   typedef struct packed {
      logic       gain_ignore_preamble;
      logic       slow_gain_rise;
      logic [3:0] front_gain_comp;
      logic [1:0] comp_ref_adjust;
   } gain_loop_cfg_t;

   typedef enum logic [1:0] {
      GAIN_HOLD = 2'b00,
      GAIN_UP   = 2'b01,
      GAIN_DOWN = 2'b10
   } gain_step_t;
endpackage

// ===== design/rx_gain_tx_shaping_regs.sv
/*
 byte-wide register bank 0x69..0x70: receive gain, gain loop options,
 transmit shaping coefficient table, transmit power and rate words.
 assumes a single-cycle register port on sys_clk already decoded by the host
 interface, and radio hints synchronous to sys_clk except tx_mode_active.
*/
// What this block does
// - with auto gain on, loop runs and its gain reads back in bits 4:0
// - with auto gain off, software-written bits 4:0 drive the applied gain
// - front amp select: 0 gives 5 dB minimum, 1 gives 25 dB maximum
// - variable amp code steps 3 dB from 0 dB, topping out at 24 dB
// - first gain register resets to 0x20, auto gain on, overrides zero
// - ignore-preamble bit makes the gain loop disregard preamble detection
// - slow rise bit slows gain increase, gain decrease speed unchanged
// - four-bit compensation smooths signal strength across front amp switching
// - second gain register resets to 0x9d
// - three-bit index picks one entry of the shaping coefficient table for 0 to 6; index 7 picks none
// - value register reads or replaces the indexed six-bit coefficient
// - table defaults 1,3,6,10,15,19,20 for indices 0 to 6
// - rx switch output high in transmit when enabled, else always low
// - three-bit power code, 000 is -8 dBm, 111 is +13 dBm
// - rate = 1000*word/2^16 kbps, or /2^21 with scale bit set
// - rate upper byte is read-write, resets to 0x0a
// - rate lower byte is read-write, resets to 0x3d, giving 40 kbps
`timescale 1ns/1ps
`include "rx_gain_tx_shaping_defs.svh"

module rx_gain_tx_shaping_regs
   import rx_gain_tx_shaping_pkg::*;
#(
   parameter int COEF_COUNT = 7,
   parameter int COEF_WIDTH = 6
)
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire reg_access_t reg_req,
   output logic [7:0]       reg_rdata,
   output logic             reg_rvalid,
   input  wire logic        tx_mode_active,
   input  wire logic        preamble_seen,
   input  wire logic        signal_high,
   input  wire logic        signal_low,
   input  wire logic [7:0]  rssi_raw,
   output gain_setting_t    applied_gain,
   output logic [7:0]       rssi_comp,
   output logic             rx_switch_ctrl,
   output logic [2:0]       tx_power_code,
   output logic [15:0]      tx_rate_word,
   output logic             tx_rate_scale,
   output logic [COEF_COUNT*COEF_WIDTH-1:0] shaping_coefs
);
   // index decode and read mux are sized for seven six-bit entries only
   if (COEF_COUNT != 7 || COEF_WIDTH != 6) begin : g_bad_table
      $error("coefficient table must be 7 entries of 6 bits");
   end

   logic           auto_gain_on;
   gain_setting_t  manual_gain;
   gain_setting_t  loop_gain;
   gain_loop_cfg_t loop_cfg;
   logic [2:0]     coef_index;
   logic [COEF_WIDTH-1:0] coef_table [COEF_COUNT];
   logic           rx_switch_ctrl_en;
   logic [7:0]     rate_high;
   logic [7:0]     rate_low;
   logic [5:0]     mod_ctrl_low;
   logic           tx_mode_meta;
   logic           tx_mode_sync;
   logic           wr;
   logic [7:0]     next_rdata;
   logic [7:0]     comp_term;
   logic [8:0]     comp_sum;
   logic           wr_gain_ovr;
   logic           wr_loop_tune;
   logic           wr_coef_idx;
   logic           wr_coef_val;
   logic           wr_power;
   logic           wr_rate_hi;
   logic           wr_rate_lo;
   logic           wr_mod_ctrl;

   // reset bytes held as named constants so single fields can be picked out
   localparam logic [7:0] gain_ovr_rst = `RST_GAIN_MANUAL_OVERRIDE;
   localparam logic [3:0] power_rst    = `RST_TX_POWER_LEVEL;

   assign wr = reg_req.wr_en;

   // one strobe per register; an unmapped offset raises none, so that write vanishes
   always_comb begin
      wr_gain_ovr  = 1'b0;
      wr_loop_tune = 1'b0;
      wr_coef_idx  = 1'b0;
      wr_coef_val  = 1'b0;
      wr_power     = 1'b0;
      wr_rate_hi   = 1'b0;
      wr_rate_lo   = 1'b0;
      wr_mod_ctrl  = 1'b0;
      if (wr) begin
         unique case (reg_req.addr)
            `OFS_GAIN_MANUAL_OVERRIDE: wr_gain_ovr  = 1'b1;
            `OFS_GAIN_LOOP_TUNING:     wr_loop_tune = 1'b1;
            `OFS_TX_SHAPING_COEF_IDX:  wr_coef_idx  = 1'b1;
            `OFS_TX_SHAPING_COEF_VAL:  wr_coef_val  = 1'b1;
            `OFS_TX_POWER_LEVEL:       wr_power     = 1'b1;
            `OFS_TX_RATE_HIGH:         wr_rate_hi   = 1'b1;
            `OFS_TX_RATE_LOW:          wr_rate_lo   = 1'b1;
            `OFS_TX_MOD_CTRL:          wr_mod_ctrl  = 1'b1;
            default:                   ;
         endcase
      end
   end

   // pin input, two stages before use
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_mode_meta <= 1'b0;
         tx_mode_sync <= 1'b0;
      end else begin
         tx_mode_meta <= tx_mode_active;
         tx_mode_sync <= tx_mode_meta;
      end
   end

   // gain override register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         auto_gain_on <= gain_ovr_rst[`BIT_AUTO_GAIN_ON];
         manual_gain  <= gain_setting_t'(gain_ovr_rst[4:0]);
      end else if (wr_gain_ovr) begin
         auto_gain_on <= reg_req.wdata[`BIT_AUTO_GAIN_ON];
         manual_gain  <= gain_setting_t'(reg_req.wdata[4:0]);
      end
   end

   // gain loop tuning register
   always_ff @(posedge sys_clk) begin
      if (rst)
         loop_cfg <= gain_loop_cfg_t'(`RST_GAIN_LOOP_TUNING);
      else if (wr_loop_tune)
         loop_cfg <= gain_loop_cfg_t'(reg_req.wdata);
   end

   auto_gain_loop u_auto_gain_loop (
      .sys_clk       (sys_clk),
      .rst           (rst),
      .enable        (auto_gain_on),
      .cfg           (loop_cfg),
      .preamble_seen (preamble_seen),
      .signal_high   (signal_high),
      .signal_low    (signal_low),
      .gain          (loop_gain)
   );

   // front amp at 25 dB adds 20 dB; with it at 5 dB, comp lifts strength by that step
   assign comp_term = {2'b00, loop_cfg.front_gain_comp, 2'b00};
   assign comp_sum  = applied_gain.front_amp_gain_sel ? {1'b0, rssi_raw}
                                                      : {1'b0, rssi_raw} + {1'b0, comp_term};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         applied_gain <= '0;
         rssi_comp    <= 8'h00;
      end else begin
         applied_gain <= auto_gain_on ? loop_gain : manual_gain;
         rssi_comp    <= comp_sum[8] ? 8'hff : comp_sum[7:0];
      end
   end

   // coefficient index
   always_ff @(posedge sys_clk) begin
      if (rst)
         coef_index <= `RST_COEF_INDEX;
      else if (wr_coef_idx)
         coef_index <= reg_req.wdata[2:0];
   end

   // coefficient table, one entry per generate slice
   function automatic logic [COEF_WIDTH-1:0] coef_default(input int idx);
      case (idx)
         0:       coef_default = `COEF_DEF_0;
         1:       coef_default = `COEF_DEF_1;
         2:       coef_default = `COEF_DEF_2;
         3:       coef_default = `COEF_DEF_3;
         4:       coef_default = `COEF_DEF_4;
         5:       coef_default = `COEF_DEF_5;
         default: coef_default = `COEF_DEF_6;
      endcase
   endfunction

   for (genvar i = 0; i < COEF_COUNT; i++) begin : g_coef
      always_ff @(posedge sys_clk) begin
         if (rst)
            coef_table[i] <= coef_default(i);
         else if (wr_coef_val && coef_index == 3'(i))
            coef_table[i] <= reg_req.wdata[COEF_WIDTH-1:0];
      end
      always_ff @(posedge sys_clk) begin
         if (rst)
            shaping_coefs[i*COEF_WIDTH +: COEF_WIDTH] <= coef_default(i);
         else
            shaping_coefs[i*COEF_WIDTH +: COEF_WIDTH] <= coef_table[i];
      end
   end

   // power register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_switch_ctrl_en <= power_rst[`BIT_RX_SWITCH_CTRL_EN];
         tx_power_code     <= power_rst[2:0];
      end else if (wr_power) begin
         rx_switch_ctrl_en <= reg_req.wdata[`BIT_RX_SWITCH_CTRL_EN];
         tx_power_code     <= reg_req.wdata[2:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst)
         rx_switch_ctrl <= 1'b0;
      else
         rx_switch_ctrl <= rx_switch_ctrl_en & tx_mode_sync;
   end

   // rate word bytes and the scale bit
   always_ff @(posedge sys_clk) begin
      if (rst)
         rate_high <= `RST_TX_RATE_HIGH;
      else if (wr_rate_hi)
         rate_high <= reg_req.wdata;
   end

   always_ff @(posedge sys_clk) begin
      if (rst)
         rate_low <= `RST_TX_RATE_LOW;
      else if (wr_rate_lo)
         rate_low <= reg_req.wdata;
   end

   // scale bit kept with its neighbours so the word here is complete
   always_ff @(posedge sys_clk) begin
      if (rst)
         mod_ctrl_low <= `RST_TX_MOD_CTRL;
      else if (wr_mod_ctrl)
         mod_ctrl_low <= reg_req.wdata[5:0];
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_rate_word  <= {`RST_TX_RATE_HIGH, `RST_TX_RATE_LOW};
         tx_rate_scale <= 1'b0;
      end else begin
         tx_rate_word  <= {rate_high, rate_low};
         tx_rate_scale <= mod_ctrl_low[`BIT_TX_RATE_SCALE];
      end
   end

   // read mux; reserved bits return zero
   always_comb begin
      next_rdata = 8'h00;
      unique case (reg_req.addr)
         `OFS_GAIN_MANUAL_OVERRIDE:
            next_rdata = {2'b00, auto_gain_on,
                          auto_gain_on ? loop_gain : manual_gain};
         `OFS_GAIN_LOOP_TUNING:    next_rdata = loop_cfg;
         `OFS_TX_SHAPING_COEF_IDX: next_rdata = {5'h00, coef_index};
         `OFS_TX_SHAPING_COEF_VAL: begin
            if (32'(coef_index) < COEF_COUNT)
               next_rdata = {2'b00, coef_table[coef_index]};
         end
         `OFS_TX_POWER_LEVEL:
            next_rdata = {4'h0, rx_switch_ctrl_en, tx_power_code};
         `OFS_TX_RATE_HIGH:        next_rdata = rate_high;
         `OFS_TX_RATE_LOW:         next_rdata = rate_low;
         `OFS_TX_MOD_CTRL:         next_rdata = {2'b00, mod_ctrl_low};
         default:                  next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rdata  <= reg_req.rd_en ? next_rdata : 8'h00;
         reg_rvalid <= reg_req.rd_en;
      end
   end
endmodule

// ===== tb/rx_gain_tx_shaping_properties.sv
/*
 concurrent checks on the ports of the receive gain / transmit shaping register bank.
 assumes one clock, sys_clk, and a synchronous active-high rst.
*/
`timescale 1ns/1ps

module rx_gain_tx_shaping_checker
   import rx_gain_tx_shaping_pkg::*;
#(
   parameter int COEF_COUNT = 7,
   parameter int COEF_WIDTH = 6
)
(
   input wire logic          sys_clk,
   input wire logic          rst,
   input wire reg_access_t   reg_req,
   input wire logic [7:0]    reg_rdata,
   input wire logic          reg_rvalid,
   input wire logic          tx_mode_active,
   input wire gain_setting_t applied_gain,
   input wire logic          rx_switch_ctrl,
   input wire logic [2:0]    tx_power_code,
   input wire logic [15:0]   tx_rate_word,
   input wire logic          tx_rate_scale
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   wire wr_gain  = reg_req.wr_en && reg_req.addr == 7'h69;
   wire wr_power = reg_req.wr_en && reg_req.addr == 7'h6d;
   wire wr_hi    = reg_req.wr_en && reg_req.addr == 7'h6e;
   wire wr_lo    = reg_req.wr_en && reg_req.addr == 7'h6f;
   wire wr_mod   = reg_req.wr_en && reg_req.addr == 7'h70;

   a_read_answer:
      assert property (reg_rvalid == $past(reg_req.rd_en))
      else $error("read answer late or spurious");
   a_manual_gain:
      assert property (wr_gain && !reg_req.wdata[5] ##1 !wr_gain
         |=> applied_gain == $past(reg_req.wdata[4:0], 2))
      else $error("manual gain not applied");
   a_power_code:
      assert property (wr_power ##1 !wr_power
         |=> tx_power_code == $past(reg_req.wdata[2:0], 2))
      else $error("power code not taken from write");
   // a disabled switch must stay low whatever the transmit pin does
   a_switch_off:
      assert property (wr_power && !reg_req.wdata[3] ##1 !wr_power [*3]
         |-> !rx_switch_ctrl [*2])
      else $error("switch output high while disabled");
   a_switch_cause:
      assert property (rx_switch_ctrl |-> $past(tx_mode_active, 2)
         || $past(tx_mode_active, 3) || $past(tx_mode_active, 4))
      else $error("switch output high outside transmit");
   a_rate_high:
      assert property (wr_hi ##1 !wr_hi |=> tx_rate_word[15:8] == $past(reg_req.wdata, 2))
      else $error("rate upper byte not applied");
   a_rate_low:
      assert property (wr_lo ##1 !wr_lo |=> tx_rate_word[7:0] == $past(reg_req.wdata, 2))
      else $error("rate lower byte not applied");
   a_rate_scale:
      assert property (wr_mod ##1 !wr_mod |=> tx_rate_scale == $past(reg_req.wdata[5], 2))
      else $error("rate scale bit not applied");
   a_unmapped_zero:
      assert property (reg_rvalid && ($past(reg_req.addr) < 7'h69
         || $past(reg_req.addr) > 7'h70) |-> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_gain_reserved:
      assert property (reg_rvalid && $past(reg_req.addr) == 7'h69 |-> reg_rdata[7:6] == 2'b00)
      else $error("reserved gain bits not zero");
endmodule

bind rx_gain_tx_shaping_regs rx_gain_tx_shaping_checker
   #(.COEF_COUNT(COEF_COUNT), .COEF_WIDTH(COEF_WIDTH)) u_checker (
   .sys_clk, .rst, .reg_req, .reg_rdata, .reg_rvalid, .tx_mode_active, .applied_gain,
   .rx_switch_ctrl, .tx_power_code, .tx_rate_word, .tx_rate_scale);

// ===== tb/tb_top.sv
/*
 self-checking bench for the register bank: port read/write tasks, reset values,
 shaping table, gain loop, power, switch and rate outputs.
 assumes the design and its checker are compiled before it.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top
   import rx_gain_tx_shaping_pkg::*;
;
   logic          sys_clk        = 1'b0;
   logic          rst            = 1'b1;
   reg_access_t   reg_req        = '0;
   logic          tx_mode_active = 1'b0;
   logic          preamble_seen  = 1'b0;
   logic          signal_high    = 1'b0;
   logic          signal_low     = 1'b0;
   logic [7:0]    rssi_raw       = 8'h10;
   logic [7:0]    reg_rdata;
   logic          reg_rvalid;
   gain_setting_t applied_gain;
   logic [7:0]    rssi_comp;
   logic          rx_switch_ctrl;
   logic [2:0]    tx_power_code;
   logic [15:0]   tx_rate_word;
   logic          tx_rate_scale;
   logic [41:0]   shaping_coefs;
   int            errors         = 0;
   int            compares       = 0;
   int            cycles         = 0;
   logic [7:0]    rst_tab [8]    = '{8'h20, 8'h9d, 8'h00, 8'h01, 8'h08, 8'h0a, 8'h3d, 8'h00};
   logic [5:0]    coef_tab [7]   = '{6'd1, 6'd3, 6'd6, 6'd10, 6'd15, 6'd19, 6'd20};

   rx_gain_tx_shaping_regs #(.COEF_COUNT(7), .COEF_WIDTH(6)) DUT (
      .sys_clk, .rst, .reg_req, .reg_rdata, .reg_rvalid, .tx_mode_active, .preamble_seen,
      .signal_high, .signal_low, .rssi_raw, .applied_gain, .rssi_comp, .rx_switch_ctrl,
      .tx_power_code, .tx_rate_word, .tx_rate_scale, .shaping_coefs);

   initial begin
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic complete_run();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 4000) begin
         errors++;
         complete_run();
      end
   end

   // returns once derived outputs have had their two cycles to settle
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge sys_clk) reg_req <= '{1'b1, 1'b0, a, d};
      @(posedge sys_clk) reg_req <= '0;
      @(posedge sys_clk) #1;
   endtask

   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge sys_clk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge sys_clk) reg_req <= '0;
      #1 `CHK({reg_rvalid, reg_rdata}, {1'b1, e})
   endtask

   task automatic wait_gain(input gain_setting_t g, input int n);
      for (int i = 0; i < n && applied_gain !== g; i++) begin
         @(posedge sys_clk);
         #1;
      end
      `CHK(applied_gain, g)
   endtask

   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      #1 `CHK(tx_rate_word, 16'h0a3d)
      for (int i = 0; i < 8; i++) rd(7'(7'h69 + i), rst_tab[i]);
      `CHK(shaping_coefs, {6'd20, 6'd19, 6'd15, 6'd10, 6'd6, 6'd3, 6'd1})
      `CHK(rssi_comp, 8'h2c)
      for (int i = 0; i < 7; i++) begin
         wr(7'h6b, 8'(i));
         rd(7'h6c, {2'b00, coef_tab[i]});
      end
      wr(7'h6c, 8'hea);
      rd(7'h6c, 8'h2a);
      `CHK(shaping_coefs[41:36], 6'h2a)
      wr(7'h6b, 8'hff);
      rd(7'h6b, 8'h07);
      rd(7'h6c, 8'h00);
      // loop still at its reset gain of zero here, so every step is predictable
      wr(7'h6a, 8'h00);
      @(posedge sys_clk) begin
         preamble_seen <= 1'b1;
         signal_low <= 1'b1;
      end
      repeat (40) @(posedge sys_clk);
      #1 `CHK(applied_gain, 5'h00)
      wr(7'h6a, 8'h80);
      wait_gain(5'h18, 40);
      rd(7'h69, 8'h38);
      `CHK(rssi_comp, 8'h10)
      wr(7'h6a, 8'hc0);
      @(posedge sys_clk) begin
         signal_low <= 1'b0;
         signal_high <= 1'b1;
      end
      wait_gain(5'h00, 30);
      @(posedge sys_clk) begin
         signal_high <= 1'b0;
         signal_low <= 1'b1;
      end
      repeat (10) @(posedge sys_clk);
      #1 `CHK(applied_gain.var_amp_gain, 4'h0)
      wait_gain(5'h18, 200);
      wr(7'h69, 8'hc5);
      rd(7'h69, 8'h05);
      `CHK(applied_gain, 5'h05)
      wr(7'h69, 8'h18);
      `CHK(applied_gain, 5'h18)
      wr(7'h6d, 8'hff);
      rd(7'h6d, 8'h0f);
      `CHK(tx_power_code, 3'h7)
      `CHK(rx_switch_ctrl, 1'b0)
      @(posedge sys_clk) tx_mode_active <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1 `CHK(rx_switch_ctrl, 1'b1)
      wr(7'h6d, 8'h00);
      `CHK(tx_power_code, 3'h0)
      `CHK(rx_switch_ctrl, 1'b0)
      wr(7'h6e, 8'h12);
      wr(7'h6f, 8'h34);
      rd(7'h6e, 8'h12);
      `CHK(tx_rate_word, 16'h1234)
      wr(7'h70, 8'hff);
      rd(7'h70, 8'h3f);
      `CHK(tx_rate_scale, 1'b1)
      wr(7'h68, 8'hff);
      rd(7'h68, 8'h00);
      rd(7'h71, 8'h00);
      complete_run();
   end
endmodule
